// File: hw/bad_decoder.sv
module bad_decoder #(
   parameter int WAIT_N = bad_pkg::WAIT_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   bad_bus_if.decoder bus,
   input wire logic single_chip_in,
   input wire logic boot_select_pin_in,
   input wire logic strobes_disabled_in,
   input wire logic [bad_pkg::BANK_W-1:0] bank_in,
   input wire logic bank_io_in,
   input wire logic [15:0] dev_rdata_in,
   output logic [bad_pkg::SEL_W-1:0] sel_out,
   output logic [bad_pkg::EXP_W-1:0] exp_addr_out,
   output logic io_write_strobe_n_out,
   output logic io_read_strobe_n_out
);
   // ==========================================
   // Elaboration checks
   // The wait counter is eight bits wide, so longer waits cannot be counted.
   if (WAIT_N < 1 || WAIT_N > 255) begin : g_bad_wait_n
      $error("bad_decoder: WAIT_N out of range");
   end
   // The bank bits and the window bits must fill the expansion address exactly.
   if (bad_pkg::BANK_W + bad_pkg::WIN_W != bad_pkg::EXP_W) begin : g_bad_exp_w
      $error("bad_decoder: expansion address widths disagree");
   end

   // ==========================================
   // Pin synchronisers
   // Mode and configuration pins are meant to be static, but a change in use must not reach the
   // decode half settled, so each passes two flip-flops before anything reads it.
   localparam int PIN_N = 3;
   localparam int PIN_BOOT = 0;
   localparam int PIN_SINGLE = 1;
   localparam int PIN_NOSTROBE = 2;
   wire [PIN_N-1:0] pin_raw = {strobes_disabled_in, single_chip_in, boot_select_pin_in};
   logic [PIN_N-1:0] pin_s1;
   logic [PIN_N-1:0] pin_sync;
   for (genvar p = 0; p < PIN_N; p++) begin : g_pin_sync
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            pin_s1[p] <= 1'b0;
            pin_sync[p] <= 1'b0;
         end else begin
            pin_s1[p] <= pin_raw[p];
            pin_sync[p] <= pin_s1[p];
         end
      end
   end
   wire boot_select = pin_sync[PIN_BOOT];
   wire single_chip = pin_sync[PIN_SINGLE];
   wire strobes_disabled = pin_sync[PIN_NOSTROBE];

   // ==========================================
   // Range decode
   logic [bad_pkg::SEL_W-1:0] next_sel;
   logic h_rom, h_dram, h_sock, h_dmaw, h_dmar, h_mix, h_exp, h_sio, h_sram, h_ovl;
   bad_range #(.LO(bad_pkg::ROM_BASE), .HI(bad_pkg::ROM_TOP)) u_rom (.addr_in(bus.addr), .hit_out(h_rom));
   bad_range #(.LO(bad_pkg::DRAM_BASE), .HI(bad_pkg::DRAM_TOP)) u_dram (.addr_in(bus.addr), .hit_out(h_dram));
   bad_range #(.LO(bad_pkg::SOCK_BASE), .HI(bad_pkg::SOCK_TOP)) u_sock (.addr_in(bus.addr), .hit_out(h_sock));
   bad_range #(.LO(bad_pkg::DMAW_BASE), .HI(bad_pkg::DMAW_TOP)) u_dmaw (.addr_in(bus.addr), .hit_out(h_dmaw));
   bad_range #(.LO(bad_pkg::DMAR_BASE), .HI(bad_pkg::DMAR_TOP)) u_dmar (.addr_in(bus.addr), .hit_out(h_dmar));
   bad_range #(.LO(bad_pkg::MIX_BASE), .HI(bad_pkg::MIX_TOP)) u_mix (.addr_in(bus.addr), .hit_out(h_mix));
   bad_range #(.LO(bad_pkg::EXP_BASE), .HI(bad_pkg::EXP_TOP)) u_exp (.addr_in(bus.addr), .hit_out(h_exp));
   bad_range #(.LO(bad_pkg::SIO_BASE), .HI(bad_pkg::SIO_TOP)) u_sio (.addr_in(bus.addr), .hit_out(h_sio));
   bad_range #(.LO(bad_pkg::SRAM_BASE), .HI(bad_pkg::SRAM_TOP)) u_sram (.addr_in(bus.addr), .hit_out(h_sram));
   bad_range #(.LO(bad_pkg::OVL_BASE), .HI(bad_pkg::SRAM_TOP)) u_ovl (.addr_in(bus.addr), .hit_out(h_ovl));

   // The flash half is picked by the address bit just below the block size.
   wire upper_half = bus.addr >= bad_pkg::ROM_UPPER;
   wire flash_hit = h_rom && single_chip && (upper_half == boot_select);
   wire rom_hit = h_rom && !flash_hit;
   // The shared pins carry strobes unless the configuration turns them off.
   wire strobes_on = !strobes_disabled;
   wire ext_free = !bus.dma_active && !strobes_on;
   // Internal RAM and peripheral registers lie over the top of the static RAM, so it stays dark there.
   wire sram_hit = h_sram && !h_ovl;
   wire sel_active = bus.req;

   // ==========================================
   // Select vector
   always_comb begin
      next_sel = '0;
      if (sel_active) begin
         next_sel[bad_pkg::SEL_ROM] = rom_hit;
         next_sel[bad_pkg::SEL_FLASH] = flash_hit;
         next_sel[bad_pkg::SEL_DRAM] = h_dram;
         next_sel[bad_pkg::SEL_SOCK] = h_sock;
         next_sel[bad_pkg::SEL_EXT4] = h_dmaw && ext_free;
         next_sel[bad_pkg::SEL_EXT5] = h_dmar && ext_free;
         next_sel[bad_pkg::SEL_EXPM] = h_exp && !bank_io_in;
         next_sel[bad_pkg::SEL_EXPI] = h_exp && bank_io_in;
         next_sel[bad_pkg::SEL_SIO] = h_sio;
         next_sel[bad_pkg::SEL_SRAM] = sram_hit;
      end
   end

   // ==========================================
   // Expansion address and strobes
   // Reserved areas, the internal overlay and locked shared blocks select nothing.
   wire any_sel = |next_sel;
   wire [bad_pkg::EXP_W-1:0] next_exp_addr = {bank_in, bus.addr[bad_pkg::WIN_W-1:0]};
   // The strobe logic cannot tell a DMA cycle from a processor cycle, so while DMA runs with the
   // strobe function on, every access pulls the matching strobe; the blocks behind them stay locked.
   wire strobe_wr = sel_active && bus.dma_active && strobes_on && bus.wr;
   wire strobe_rd = sel_active && bus.dma_active && strobes_on && !bus.wr;

   // ==========================================
   // Wait sequencer for the seventh block
   typedef enum logic [2:0] {
      BAD_IDLE = 3'b001,
      BAD_WAIT = 3'b010,
      BAD_DONE = 3'b100
   } bad_state_t;
   bad_state_t state, next_state;
   logic [7:0] cnt;
   // Every access in the seventh block waits; the count runs from zero in the wait state, so WAIT_N
   // cycles of wait request stand before the end pulse.
   wire mix_access = sel_active && h_mix;

   always_comb begin
      next_state = state;
      unique case (state)
         BAD_IDLE: begin
            // An access that selects nothing still ends, so the processor side is never left
            // waiting for an answer that cannot come; it simply sees no read data.
            if (mix_access) next_state = BAD_WAIT;
            else if (sel_active) next_state = BAD_DONE;
         end
         BAD_WAIT: begin
            if (cnt == 8'(WAIT_N - 1)) next_state = BAD_DONE;
         end
         BAD_DONE: begin
            next_state = BAD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= BAD_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= (state == BAD_WAIT) ? cnt + 8'h01 : 8'h00;
      end
   end

   // ==========================================
   // Select and expansion address outputs
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sel_out <= '0;
         exp_addr_out <= '0;
      end else begin
         sel_out <= (state == BAD_DONE) ? '0 : next_sel;
         exp_addr_out <= next_exp_addr;
      end
   end

   // ==========================================
   // Shared strobe outputs
   // Both strobes are active low, reset high, and go low only for an access while DMA runs with the strobe function on.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         io_write_strobe_n_out <= 1'b1;
         io_read_strobe_n_out <= 1'b1;
      end else begin
         io_write_strobe_n_out <= !strobe_wr;
         io_read_strobe_n_out <= !strobe_rd;
      end
   end

   // ==========================================
   // Bus response
   // Read data goes out only for a selected read, so hidden and reserved addresses leave the bus undriven.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus.rdata <= 16'h0000;
         bus.rdata_oe <= 1'b0;
         bus.wait_req <= 1'b0;
         bus.done <= 1'b0;
      end else begin
         bus.rdata <= any_sel ? dev_rdata_in : 16'h0000;
         bus.rdata_oe <= any_sel && !bus.wr && (next_state == BAD_DONE);
         bus.wait_req <= mix_access && (next_state != BAD_DONE);
         bus.done <= (next_state == BAD_DONE);
      end
   end
endmodule

// File: hw/bad_pkg.sv
package bad_pkg;
   // ==========================================
   // Address map, 26-bit processor byte addresses.
   localparam int ADDR_W = 26;
   localparam logic [25:0] ROM_BASE = 26'h000_0000;
   localparam logic [25:0] ROM_TOP = 26'h01F_FFFF;
   localparam logic [25:0] ROM_MID = 26'h00F_FFFF;
   localparam logic [25:0] ROM_UPPER = 26'h010_0000;
   localparam logic [25:0] RSV1_BASE = 26'h020_0000;
   localparam logic [25:0] RSV1_TOP = 26'h03F_FFFF;
   localparam logic [25:0] DRAM_BASE = 26'h040_0000;
   localparam logic [25:0] DRAM_TOP = 26'h07F_FFFF;
   localparam logic [25:0] SOCK_BASE = 26'h080_0000;
   localparam logic [25:0] SOCK_TOP = 26'h0FF_FFFF;
   localparam logic [25:0] DMAW_BASE = 26'h300_0000;
   localparam logic [25:0] DMAW_TOP = 26'h37F_FFFF;
   localparam logic [25:0] DMAR_BASE = 26'h380_0000;
   localparam logic [25:0] DMAR_TOP = 26'h3BF_FFFF;
   localparam logic [25:0] MIX_BASE = 26'h3C0_0000;
   localparam logic [25:0] MIX_TOP = 26'h3DF_FFFF;
   localparam logic [25:0] RSV6_TOP = 26'h3CF_FFFF;
   localparam logic [25:0] EXP_BASE = 26'h3D0_0000;
   localparam logic [25:0] EXP_TOP = 26'h3D7_FFFF;
   localparam logic [25:0] SIO_BASE = 26'h3D8_0000;
   localparam logic [25:0] SIO_TOP = 26'h3DF_FFFF;
   localparam logic [25:0] SRAM_BASE = 26'h3E0_0000;
   localparam logic [25:0] SRAM_TOP = 26'h3FF_FFFF;
   localparam logic [25:0] OVL_BASE = 26'h3FF_E000;
   // ==========================================
   // Expansion window: 19 low bits pass, bank supplies 5 upper bits of 24.
   localparam int WIN_W = 19;
   localparam int EXP_W = 24;
   localparam int BANK_W = 5;
   localparam int WAIT_CYCLES = 2;
   // ==========================================
   // Select vector bit positions.
   localparam int SEL_ROM = 0;
   localparam int SEL_FLASH = 1;
   localparam int SEL_DRAM = 2;
   localparam int SEL_SOCK = 3;
   localparam int SEL_EXT4 = 4;
   localparam int SEL_EXT5 = 5;
   localparam int SEL_EXPM = 6;
   localparam int SEL_EXPI = 7;
   localparam int SEL_SIO = 8;
   localparam int SEL_SRAM = 9;
   localparam int SEL_W = 10;
endpackage

// File: hw/bad_bus_if.sv
interface bad_bus_if;
   logic req;
   logic [25:0] addr;
   logic wr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic rdata_oe;
   logic wait_req;
   logic done;
   logic dma_active;
   modport decoder (input req, addr, wr, wdata, dma_active, output rdata, rdata_oe, wait_req, done);
   modport processor (output req, addr, wr, wdata, dma_active, input rdata, rdata_oe, wait_req, done);
endinterface

// File: hw/bad_range.sv
module bad_range #(
   parameter logic [25:0] LO = 26'h000_0000,
   parameter logic [25:0] HI = 26'h000_0000
) (
   input wire logic [25:0] addr_in,
   output logic hit_out
);
   if (LO > HI) begin : g_bad_bounds
      $error("bad_range: LO above HI");
   end
   assign hit_out = (addr_in >= LO) && (addr_in <= HI);
endmodule

// File: hw/bad_processor.sv
module bad_processor (
   input wire logic clk_in,
   input wire logic resetn_in,
   bad_bus_if.processor bus,
   input wire logic cmd_valid_in,
   input wire logic [25:0] cmd_addr_in,
   input wire logic cmd_wr_in,
   input wire logic [15:0] cmd_wdata_in,
   input wire logic dma_active_in,
   output logic cmd_ready_out,
   output logic cmd_refused_out,
   output logic [15:0] cmd_rdata_out,
   output logic cmd_done_out
);
   // ==========================================
   // Reserved ranges are refused here, never driven onto the bus.
   wire in_rsv1 = (cmd_addr_in >= bad_pkg::RSV1_BASE) && (cmd_addr_in <= bad_pkg::RSV1_TOP);
   wire in_rsv6 = (cmd_addr_in >= bad_pkg::MIX_BASE) && (cmd_addr_in <= bad_pkg::RSV6_TOP);
   wire in_shared = (cmd_addr_in >= bad_pkg::DMAW_BASE) && (cmd_addr_in <= bad_pkg::DMAR_TOP);
   wire refuse = in_rsv1 || in_rsv6 || (in_shared && dma_active_in);
   logic busy;
   wire take = cmd_valid_in && !busy;

   // ROM and SRAM waits would be programmed in the core; this end simply waits for done.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy <= 1'b0;
         bus.req <= 1'b0;
         bus.addr <= '0;
         bus.wr <= 1'b0;
         bus.wdata <= 16'h0000;
         bus.dma_active <= 1'b0;
         cmd_ready_out <= 1'b0;
         cmd_refused_out <= 1'b0;
         cmd_rdata_out <= 16'h0000;
         cmd_done_out <= 1'b0;
      end else begin
         bus.dma_active <= dma_active_in;
         cmd_refused_out <= take && refuse;
         cmd_done_out <= busy && bus.done;
         cmd_ready_out <= !busy && !(take && !refuse) || (busy && bus.done);
         if (take && !refuse) begin
            busy <= 1'b1;
            bus.req <= 1'b1;
            bus.addr <= cmd_addr_in;
            bus.wr <= cmd_wr_in;
            bus.wdata <= cmd_wdata_in;
         end else if (busy && bus.done) begin
            busy <= 1'b0;
            bus.req <= 1'b0;
            cmd_rdata_out <= bus.rdata_oe ? bus.rdata : 16'h0000;
         end
      end
   end
endmodule

// File: tb/bad_checker_props.sv
module bad_checker_props (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic req,
   input wire logic [25:0] addr,
   input wire logic wr,
   input wire logic rdata_oe,
   input wire logic wait_req,
   input wire logic done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // ==========================================
   // Address classes.
   wire logic low_hit = (addr <= bad_pkg::SOCK_TOP) && !(addr >= bad_pkg::RSV1_BASE && addr <= bad_pkg::RSV1_TOP);
   wire logic plain = low_hit || (addr >= bad_pkg::SRAM_BASE && addr < bad_pkg::OVL_BASE);
   wire logic sev = (addr >= bad_pkg::EXP_BASE) && (addr <= bad_pkg::SIO_TOP);
   property p_plain_done;
      $rose(req) && plain |-> ##1 done;
   endproperty
   a_plain_done: assert property (p_plain_done) else $error("plain access not ended in time");
   property p_sev_wait;
      $rose(req) && sev |-> ##1 wait_req [*2] ##1 done;
   endproperty
   a_sev_wait: assert property (p_sev_wait) else $error("seventh block wait or end wrong");
   property p_no_wait_plain;
      $rose(req) && plain |-> !wait_req [*3];
   endproperty
   a_no_wait_plain: assert property (p_no_wait_plain) else $error("wait raised outside seventh block");
   property p_oe_only_read;
      rdata_oe |-> done && !wr;
   endproperty
   a_oe_only_read: assert property (p_oe_only_read) else $error("read data driven out of turn");
   property p_read_oe;
      $rose(req) && plain && !wr |-> ##1 rdata_oe;
   endproperty
   a_read_oe: assert property (p_read_oe) else $error("read data not driven");
   property p_done_pulse;
      done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("end pulse too long");
   property p_req_hold;
      req && !done |=> req && $stable(addr);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_wait_ends;
      wait_req |-> !done;
   endproperty
   a_wait_ends: assert property (p_wait_ends) else $error("wait overlaps end");
endmodule

// File: tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0;
   logic resetn_in = 0;
   logic cmd_valid = 0, cmd_wr = 0, single_chip = 0, boot_sel = 0, strobes_off = 0, bank_io = 0, dma = 0;
   logic [25:0] cmd_addr = '0;
   logic [4:0] bank = 5'h00;
   logic [bad_pkg::SEL_W-1:0] sel, last_sel;
   logic [23:0] exp_addr, last_exp;
   logic wr_n, rd_n, ready, refused, cdone, saw_rd, saw_wr;
   logic [15:0] rdata;
   int n_mismatch = 0;
   int tests_run = 0;
   always #2.5 clk_in = ~clk_in;
   bad_bus_if bus ();
   bad_processor bad_processor_i (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus), .cmd_valid_in(cmd_valid),
      .cmd_addr_in(cmd_addr), .cmd_wr_in(cmd_wr), .cmd_wdata_in(16'h5A3C), .dma_active_in(dma),
      .cmd_ready_out(ready), .cmd_refused_out(refused), .cmd_rdata_out(rdata), .cmd_done_out(cdone));
   bad_decoder bad_decoder_i (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus), .single_chip_in(single_chip),
      .boot_select_pin_in(boot_sel), .strobes_disabled_in(strobes_off), .bank_in(bank), .bank_io_in(bank_io),
      .dev_rdata_in(16'hA5C3), .sel_out(sel), .exp_addr_out(exp_addr), .io_write_strobe_n_out(wr_n),
      .io_read_strobe_n_out(rd_n));
   bad_checker_props bad_checker_props_i (.clk_in(clk_in), .resetn_in(resetn_in), .req(bus.req), .addr(bus.addr),
      .wr(bus.wr), .rdata_oe(bus.rdata_oe), .wait_req(bus.wait_req), .done(bus.done));
   // ==========================================
   // Sticky capture, because the select stands only while the access runs.
   always @(posedge clk_in) begin
      if (sel != '0) begin
         last_sel <= sel;
         last_exp <= exp_addr;
      end
      if (rd_n === 1'b0) saw_rd <= 1'b1;
      if (wr_n === 1'b0) saw_wr <= 1'b1;
   end
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic access(input logic [25:0] a, input logic w, output logic was_refused);
      int i = 0;
      @(posedge clk_in);
      last_sel <= '0;
      cmd_addr <= a;
      cmd_wr <= w;
      cmd_valid <= 1'b1;
      @(posedge clk_in);
      cmd_valid <= 1'b0;
      #1;
      while (cdone !== 1'b1 && refused !== 1'b1 && i < 40) begin
         @(posedge clk_in);
         #1;
         i++;
         if (i == 1 && cdone !== 1'b1) check("busy ready", ready, 0);
      end
      was_refused = refused;
      if (i >= 40) check("no answer", 1, 0);
      check("ready", ready, 1);
      @(posedge clk_in);
   endtask
   task automatic expect_sel(input logic [25:0] a, input int bit_n);
      logic r;
      access(a, 1'b0, r);
      check("refused", r, 0);
      check("select", last_sel, 32'(1) << bit_n);
   endtask
   task automatic expect_refuse(input logic [25:0] a);
      logic r;
      access(a, 1'b0, r);
      check("refused", r, 1);
      check("select", last_sel, 0);
   endtask
   task automatic expect_none(input logic [25:0] a);
      logic r;
      access(a, 1'b0, r);
      check("refused", r, 0);
      check("select", last_sel, 0);
      check("undriven read", rdata, 0);
   endtask
   // ==========================================
   // Scenarios.
   task automatic t_map;
      logic r;
      expect_sel(26'h000_0000, bad_pkg::SEL_ROM);
      check("read data", rdata, 16'hA5C3);
      expect_sel(26'h01F_FFFE, bad_pkg::SEL_ROM);
      expect_sel(26'h07F_FFFE, bad_pkg::SEL_DRAM);
      expect_sel(26'h080_0000, bad_pkg::SEL_SOCK);
      expect_sel(26'h3E0_0000, bad_pkg::SEL_SRAM);
      expect_sel(26'h3FF_DFFE, bad_pkg::SEL_SRAM);
      expect_none(26'h3FF_E000);
      expect_none(26'h3FF_FFFE);
      expect_sel(26'h3D8_0000, bad_pkg::SEL_SIO);
      access(26'h3DF_FFFE, 1'b1, r);
      check("write select", last_sel, 32'(1) << bad_pkg::SEL_SIO);
   endtask
   task automatic t_flash;
      single_chip <= 1'b1;
      boot_sel <= 1'b0;
      repeat (4) @(posedge clk_in);
      expect_sel(26'h000_0000, bad_pkg::SEL_FLASH);
      expect_sel(26'h010_0000, bad_pkg::SEL_ROM);
      boot_sel <= 1'b1;
      repeat (4) @(posedge clk_in);
      expect_sel(26'h01F_FFFE, bad_pkg::SEL_FLASH);
      expect_sel(26'h00F_FFFE, bad_pkg::SEL_ROM);
      single_chip <= 1'b0;
   endtask
   task automatic t_exp;
      bank <= 5'h15;
      expect_sel(26'h3D7_FFFE, bad_pkg::SEL_EXPM);
      check("expansion address", last_exp, {5'h15, 19'h7_FFFE});
      bank_io <= 1'b1;
      expect_sel(26'h3D0_1234, bad_pkg::SEL_EXPI);
      check("expansion address", last_exp, {5'h15, 19'h0_1234});
      bank_io <= 1'b0;
   endtask
   task automatic t_dma;
      logic r;
      dma <= 1'b1;
      saw_rd <= 1'b0;
      saw_wr <= 1'b0;
      expect_refuse(26'h300_0000);
      expect_refuse(26'h3BF_FFFE);
      expect_sel(26'h3D8_0000, bad_pkg::SEL_SIO);
      check("read strobe", saw_rd, 1);
      access(26'h3D8_0010, 1'b1, r);
      check("write refused", r, 0);
      check("write strobe", saw_wr, 1);
      dma <= 1'b0;
      expect_none(26'h300_0000);
      strobes_off <= 1'b1;
      expect_sel(26'h37F_FFFE, bad_pkg::SEL_EXT4);
      expect_sel(26'h380_0000, bad_pkg::SEL_EXT5);
      strobes_off <= 1'b0;
      expect_refuse(26'h020_0000);
      expect_refuse(26'h3C0_0000);
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      t_map();
      t_flash();
      t_exp();
      t_dma();
      report_and_stop();
   end
   initial begin
      #20000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
